// ==== core/mqos_defs.vh ====
// Constants for the measurement query and operation status block
`ifndef MQOS_DEFS_VH
`define MQOS_DEFS_VH
// ==========================================================
// Register byte addresses
`define MQOS_A_CMD      8'h00
`define MQOS_A_STATUS   8'h04
`define MQOS_A_ERRQ     8'h08
`define MQOS_A_COND     8'h10
`define MQOS_A_ENABLE   8'h14
`define MQOS_A_EVENT    8'h18
`define MQOS_A_FALL     8'h1c
`define MQOS_A_RISE     8'h20
`define MQOS_A_RESP0    8'h40
`define MQOS_A_RESP9    8'h64
// ==========================================================
// Command word fields and opcodes
`define MQOS_OP_LSB     0
`define MQOS_OP_MSB     3
`define MQOS_ARG_LSB    4
`define MQOS_ARG_MSB    6
`define MQOS_OP_HCUR    4'h0
`define MQOS_OP_HRAT    4'h1
`define MQOS_OP_FREQ    4'h2
`define MQOS_OP_APP     4'h3
`define MQOS_OP_PF      4'h4
`define MQOS_OP_REAC    4'h5
`define MQOS_OP_REAL    4'h6
`define MQOS_OP_VRMS    4'h7
`define MQOS_OP_VHIGH   4'h8
`define MQOS_OP_VLOW    4'h9
`define MQOS_OP_VAVG    4'ha
`define MQOS_OP_DSET    4'hb
`define MQOS_OP_DGET    4'hc
`define MQOS_OP_CLS     4'hd
// ==========================================================
// Display selection codes
`define MQOS_DISP_RMS   3'h0
`define MQOS_DISP_GRP1  3'h3
`define MQOS_DISP_GRP4  3'h6
// ==========================================================
// Output mode codes
`define MQOS_MODE_INT_AC      3'h0
`define MQOS_MODE_SYNC_AC     3'h1
`define MQOS_MODE_SYNC_ACDC   3'h2
// ==========================================================
// Scaled limits and sentinels (16 bit two's complement)
`define MQOS_ZERO       16'h0000
`define MQOS_HCUR_FS    16'h05dc
`define MQOS_HRAT_FS    16'h1388
`define MQOS_FREQ_MIN   16'h017c
`define MQOS_FREQ_MAX   16'h1482
`define MQOS_APP_FS     16'h0578
`define MQOS_REAC_FS    16'h0578
`define MQOS_REAL_FS    16'h04b0
`define MQOS_PF_MAX     16'h0064
`define MQOS_V01_LO     16'h09c4
`define MQOS_V01_HI     16'h1388
`define MQOS_VPK_LO     16'h00fa
`define MQOS_VPK_HI     16'h01f4
`define MQOS_S9999      16'h270f
`define MQOS_S999       16'h03e7
`define MQOS_SNEG999    16'hfc19
// ==========================================================
// Error codes and queue
`define MQOS_ERR_MODE   16'h0003
`define MQOS_ERR_BUSY   16'h0004
`define MQOS_ERR_FREQ   16'h0006
`define MQOS_ERR_MANY   16'hfea2
`define MQOS_EQ_DEPTH   5'h14
// ==========================================================
// Operation status mask and harmonic scan end
`define MQOS_EVENT_LATCH_A_MASK  15'h5002
`define MQOS_HARM_LAST  4'h9
`endif

// ==== core/mqos_errq.v ====
// Error queue: twenty entry first-in first-out with overflow marker
`include "mqos_defs.vh"
`default_nettype none
module mqos_errq (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clr,
  input  wire        push,
  input  wire [15:0] code,
  input  wire        pop,
  output wire [15:0] head,
  output reg  [4:0]  count
);
  // ========================================================
  // Storage, entry 0 is the oldest
  wire [15:0] ent [0:20];
  wire        do_pop;
  wire        full;
  wire [4:0]  wr_pos;
  assign do_pop = pop & (count != 5'h00);
  assign full   = (count == `MQOS_EQ_DEPTH);
  assign wr_pos = do_pop ? count - 5'h01 : count;
  assign head   = ent[0];
  assign ent[20] = 16'h0000;
  genvar i;
  generate
    for (i = 0; i < 20; i = i + 1)
    begin : g_ent
      reg [15:0] val;
      assign ent[i] = val;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          val <= 16'h0000;
        else if (clr)
          val <= 16'h0000;
        else if (push && full && !do_pop && i == 19)
          val <= `MQOS_ERR_MANY;
        else if (push && wr_pos == i)
          val <= code;
        else if (do_pop)
          val <= ent[i + 1];
      end
    end
  endgenerate
  // ========================================================
  // Fill level
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 5'h00;
    else if (clr)
      count <= 5'h00;
    else if (push && !do_pop && !full)
      count <= count + 5'h01;
    else if (do_pop && !push)
      count <= count - 5'h01;
  end
endmodule
`default_nettype wire

// ==== core/mqos_core.v ====
// Measurement query interpreter and operation status registers on APB
`include "mqos_defs.vh"
`default_nettype none
module mqos_core (
  input  wire               pclk,
  input  wire               presetn,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  input  wire [2:0]         out_mode,
  input  wire               freq_is_50_60,
  input  wire               range_high,
  input  wire [14:0]        event_latch_a_cond_in,
  input  wire signed [15:0] meas_harm_cur,
  input  wire signed [15:0] meas_harm_ratio,
  input  wire signed [15:0] meas_sync_freq,
  input  wire signed [15:0] meas_app_pwr,
  input  wire signed [15:0] meas_pf,
  input  wire signed [15:0] meas_reac_pwr,
  input  wire signed [15:0] meas_real_pwr,
  input  wire signed [15:0] meas_v_rms,
  input  wire signed [15:0] meas_v_high,
  input  wire signed [15:0] meas_v_low,
  input  wire signed [15:0] meas_v_avg,
  output reg  [5:0]         meas_harm_index,
  output reg                event_latch_a_summary,
  output reg  [2:0]         disp_sel
);
  // ========================================================
  // Range check with sentinel substitution
  function signed [15:0] fit;
    input signed [15:0] v;
    input signed [15:0] lo;
    input signed [15:0] hi;
    input signed [15:0] sent;
    begin
      fit = (v < lo || v > hi) ? sent : v;
    end
  endfunction
  // ========================================================
  // State
  reg        busy;
  reg        hkind;
  reg [3:0]  hcnt;
  reg        last_ok;
  reg        last_bad;
  reg        err_rd_ok;
  reg [14:0] cond;
  reg [14:0] enable;
  reg [14:0] event_latch_a;
  reg [14:0] fall_filt;
  reg [14:0] rise_filt;
  // ========================================================
  // Bus decode
  wire        setup;
  wire        acc;
  wire        wr_acc;
  wire        rd_acc;
  wire [3:0]  op;
  wire [2:0]  arg;
  wire        cmd_go;
  wire [15:0] eq_head;
  wire [4:0]  eq_count;
  assign setup  = psel & ~penable;
  assign acc    = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign op     = pwdata[`MQOS_OP_MSB:`MQOS_OP_LSB];
  assign arg    = pwdata[`MQOS_ARG_MSB:`MQOS_ARG_LSB];
  // Commands arriving during a harmonic scan are dropped, not queued
  assign cmd_go = wr_acc & (paddr == `MQOS_A_CMD) & ~busy;
  // ========================================================
  // Scaled limits
  wire signed [15:0] v01_fs;
  wire signed [15:0] vpk_fs;
  wire signed [15:0] hval;
  wire               harm_disp;
  wire               sync_mode;
  wire [5:0]         harm_base;
  assign v01_fs    = range_high ? `MQOS_V01_HI : `MQOS_V01_LO;
  assign vpk_fs    = range_high ? `MQOS_VPK_HI : `MQOS_VPK_LO;
  assign harm_disp = (disp_sel >= `MQOS_DISP_GRP1);
  assign sync_mode = (out_mode == `MQOS_MODE_SYNC_AC) ||
                     (out_mode == `MQOS_MODE_SYNC_ACDC);
  assign harm_base = {3'h0, arg} * 6'h0a - 6'h09;
  assign hval = hkind ?
    fit(meas_harm_ratio, `MQOS_ZERO, `MQOS_HRAT_FS, `MQOS_S9999) :
    fit(meas_harm_cur, `MQOS_ZERO, `MQOS_HCUR_FS, `MQOS_S9999);
  // ========================================================
  // Command decode
  reg        c_err;
  reg [15:0] c_code;
  reg        c_bad;
  reg        c_we;
  reg [15:0] c_val;
  reg        c_hstart;
  reg        c_dset;
  reg        c_cls;
  always @*
  begin
    c_err    = 1'b0;
    c_code   = 16'h0000;
    c_bad    = 1'b0;
    c_we     = 1'b0;
    c_val    = 16'h0000;
    c_hstart = 1'b0;
    c_dset   = 1'b0;
    c_cls    = 1'b0;
    if (cmd_go)
    begin
      if (harm_disp && op != `MQOS_OP_HCUR && op != `MQOS_OP_HRAT &&
          op != `MQOS_OP_DSET)
      begin
        c_err  = 1'b1;
        c_code = `MQOS_ERR_BUSY;
      end
      else
      begin
        c_we = 1'b1;
        case (op)
          `MQOS_OP_HCUR, `MQOS_OP_HRAT:
          begin
            c_we = 1'b0;
            if (arg < 3'h1 || arg > 3'h4)
              c_bad = 1'b1;
            else
              c_hstart = 1'b1;
          end
          `MQOS_OP_FREQ:
          begin
            if (!sync_mode)
            begin
              c_we   = 1'b0;
              c_err  = 1'b1;
              c_code = `MQOS_ERR_MODE;
            end
            else
              c_val = fit(meas_sync_freq, `MQOS_FREQ_MIN,
                          `MQOS_FREQ_MAX, `MQOS_S9999);
          end
          `MQOS_OP_APP:
            c_val = fit(meas_app_pwr, `MQOS_ZERO, `MQOS_APP_FS,
                        `MQOS_S9999);
          `MQOS_OP_PF:
            c_val = fit(meas_pf, `MQOS_ZERO, `MQOS_PF_MAX,
                        `MQOS_S999);
          `MQOS_OP_REAC:
            c_val = fit(meas_reac_pwr, `MQOS_ZERO, `MQOS_REAC_FS,
                        `MQOS_S9999);
          `MQOS_OP_REAL:
            c_val = fit(meas_real_pwr, `MQOS_ZERO, `MQOS_REAL_FS,
                        `MQOS_S9999);
          `MQOS_OP_VRMS:
            c_val = fit(meas_v_rms, `MQOS_ZERO, v01_fs, `MQOS_S9999);
          `MQOS_OP_VHIGH:
            c_val = fit(meas_v_high, -vpk_fs, vpk_fs, `MQOS_S999);
          `MQOS_OP_VLOW:
            c_val = fit(meas_v_low, -vpk_fs, vpk_fs, `MQOS_SNEG999);
          `MQOS_OP_VAVG:
            c_val = fit(meas_v_avg, -v01_fs, v01_fs, `MQOS_S9999);
          `MQOS_OP_DSET:
          begin
            c_we = 1'b0;
            if (arg > `MQOS_DISP_GRP4)
              c_bad = 1'b1;
            else if (arg >= `MQOS_DISP_GRP1 &&
                     out_mode == `MQOS_MODE_INT_AC && !freq_is_50_60)
            begin
              c_err  = 1'b1;
              c_code = `MQOS_ERR_FREQ;
            end
            else
              c_dset = 1'b1;
          end
          `MQOS_OP_DGET:
            c_val = {13'h0000, disp_sel};
          `MQOS_OP_CLS:
          begin
            c_we  = 1'b0;
            c_cls = 1'b1;
          end
          default:
          begin
            c_we  = 1'b0;
            c_bad = 1'b1;
          end
        endcase
      end
    end
  end
  // ========================================================
  // Result slots, one per harmonic order of a group
  wire        slot_we;
  wire [3:0]  slot_wi;
  wire [15:0] slot_wd;
  wire [3:0]  slot_ri;
  wire [15:0] slot_rd [0:9];
  wire [7:0]  slot_off;
  assign slot_we  = c_we | busy;
  assign slot_wi  = busy ? hcnt : 4'h0;
  assign slot_wd  = busy ? hval : c_val;
  assign slot_off = paddr - `MQOS_A_RESP0;
  assign slot_ri  = slot_off[5:2];
  genvar i;
  generate
    for (i = 0; i < 10; i = i + 1)
    begin : g_slot
      reg [15:0] val;
      assign slot_rd[i] = val;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          val <= 16'h0000;
        else if (slot_we && slot_wi == i)
          val <= slot_wd;
      end
    end
  endgenerate
  // ========================================================
  // Harmonic scan: index out, value taken back in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy            <= 1'b0;
      hkind           <= 1'b0;
      hcnt            <= 4'h0;
      meas_harm_index <= 6'h00;
    end
    else if (c_hstart)
    begin
      busy            <= 1'b1;
      hkind           <= (op == `MQOS_OP_HRAT);
      hcnt            <= 4'h0;
      meas_harm_index <= harm_base;
    end
    else if (busy)
    begin
      hcnt            <= hcnt + 4'h1;
      // Index parks on the last order so it never points past 40
      if (hcnt == `MQOS_HARM_LAST)
        busy <= 1'b0;
      else
        meas_harm_index <= meas_harm_index + 6'h01;
    end
  end
  // ========================================================
  // Command status and display selection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_ok  <= 1'b0;
      last_bad <= 1'b0;
      disp_sel <= `MQOS_DISP_RMS;
    end
    else if (cmd_go)
    begin
      last_ok  <= ~c_err & ~c_bad;
      last_bad <= c_bad;
      if (c_dset)
        disp_sel <= arg;
    end
  end
  // ========================================================
  // Error queue
  wire eq_pop;
  assign eq_pop = rd_acc & (paddr == `MQOS_A_ERRQ) & err_rd_ok;
  mqos_errq u_errq (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (c_cls),
    .push    (c_err),
    .code    (c_code),
    .pop     (eq_pop),
    .head    (eq_head),
    .count   (eq_count)
  );
  // ========================================================
  // Operation status registers
  wire [14:0] next_cond;
  wire [14:0] ev_set;
  wire [14:0] ev_clr;
  wire [14:0] next_event;
  assign next_cond = event_latch_a_cond_in & `MQOS_EVENT_LATCH_A_MASK;
  assign ev_set = (fall_filt & cond & ~next_cond) |
                  (rise_filt & ~cond & next_cond);
  // On an event read, only bits already read are cleared, so a late set is kept
  assign ev_clr = c_cls ? 15'h7fff :
                  (rd_acc && paddr == `MQOS_A_EVENT) ? prdata[14:0] :
                  15'h0000;
  assign next_event = (event_latch_a & ~ev_clr) | ev_set;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond          <= 15'h0000;
      enable        <= 15'h0000;
      event_latch_a <= 15'h0000;
      fall_filt     <= 15'h0000;
      rise_filt     <= 15'h0000;
      event_latch_a_summary  <= 1'b0;
    end
    else
    begin
      cond          <= next_cond;
      event_latch_a <= next_event;
      event_latch_a_summary  <= |(next_event & enable);
      if (wr_acc && paddr == `MQOS_A_ENABLE)
        enable <= pwdata[14:0] & `MQOS_EVENT_LATCH_A_MASK;
      if (wr_acc && paddr == `MQOS_A_FALL)
        fall_filt <= pwdata[14:0] & `MQOS_EVENT_LATCH_A_MASK;
      if (wr_acc && paddr == `MQOS_A_RISE)
        rise_filt <= pwdata[14:0] & `MQOS_EVENT_LATCH_A_MASK;
    end
  end
  // ========================================================
  // APB read mux and answer, one wait-free access cycle
  reg [31:0] rd_data;
  reg        rd_hit;
  always @*
  begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (paddr)
      `MQOS_A_CMD:    rd_data = 32'h00000000;
      `MQOS_A_STATUS: rd_data = {19'h00000, eq_count, 1'b0, disp_sel,
                                 1'b0, last_bad, last_ok, busy};
      `MQOS_A_ERRQ:   rd_data = {{16{eq_head[15]}}, eq_head};
      `MQOS_A_COND:   rd_data = {17'h00000, cond};
      `MQOS_A_ENABLE: rd_data = {17'h00000, enable};
      `MQOS_A_EVENT:  rd_data = {17'h00000, event_latch_a};
      `MQOS_A_FALL:   rd_data = {17'h00000, fall_filt};
      `MQOS_A_RISE:   rd_data = {17'h00000, rise_filt};
      default:
      begin
        if (paddr >= `MQOS_A_RESP0 && paddr <= `MQOS_A_RESP9 &&
            paddr[1:0] == 2'h0)
          rd_data = {{16{slot_rd[slot_ri][15]}}, slot_rd[slot_ri]};
        else
          rd_hit = 1'b0;
      end
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      err_rd_ok <= 1'b0;
    end
    else if (setup)
    begin
      prdata    <= pwrite ? 32'h00000000 : rd_data;
      pready    <= 1'b1;
      pslverr   <= ~rd_hit;
      err_rd_ok <= (eq_count != 5'h00);
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/mqos_core_asserts.sv ====
// Port checker for the measurement query core
`include "mqos_defs.vh"
`default_nettype none
// ======
// Checker
module mqos_core_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  meas_harm_index,
  input wire logic        event_latch_a_summary,
  input wire logic [2:0]  disp_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  wire setup = psel && !penable;
  wire wacc  = psel && penable && pready && pwrite;
  wire wcmd  = wacc && paddr == `MQOS_A_CMD;
  default clocking dck @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_write_zero: assert property (setup && pwrite |=> prdata == 32'h0)
    else $error("read data not zero on write");
  a_err_unmapped: assert property (setup && (paddr == 8'h0c ||
    paddr > `MQOS_A_RESP9) |=> pready && pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (setup && paddr >= `MQOS_A_COND &&
    paddr <= `MQOS_A_RISE && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access flagged");
  a_disp_legal: assert property (disp_sel <= 3'h6)
    else $error("display code out of range");
  a_disp_cause: assert property (!$stable(disp_sel) |-> $past(wcmd))
    else $error("display changed without command");
  a_disp_rms: assert property (wcmd && pwdata[6:0] == 7'h0b
    |=> disp_sel == 3'h0)
    else $error("display not set to rms");
  a_sum_masked: assert property (wacc && paddr == `MQOS_A_ENABLE &&
    (pwdata & 32'h5002) == 32'h0 |-> ##2 !event_latch_a_summary)
    else $error("summary with empty enable");
  a_idx_start: assert property (wcmd && pwdata[3:1] == 3'h0 &&
    pwdata[6:4] != 3'h0 && pwdata[6:4] <= 3'h4 |=>
    meas_harm_index == {3'h0, $past(pwdata[6:4])} * 6'h0a - 6'h09)
    else $error("harmonic index wrong start");
  a_idx_bound: assert property (meas_harm_index <= 6'h28)
    else $error("harmonic index beyond order 40");
  c_last_order: cover property (meas_harm_index == 6'h28);
  c_unmapped: cover property (pready && pslverr);
  c_summary: cover property ($rose(event_latch_a_summary));
endmodule
bind mqos_core mqos_core_chk i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .meas_harm_index, .event_latch_a_summary,
  .disp_sel
);
`default_nettype wire

// ==== verif/mqos_front_model.sv ====
// Measurement front end model feeding the query core
`default_nettype none
// ======
// Front end
module mqos_front_model (
  input  wire logic        [5:0]  harm_index,
  input  wire logic signed [15:0] level,
  output logic signed      [15:0] harm_cur,
  output logic signed      [15:0] harm_ratio,
  output logic signed      [15:0] scalar
);
  timeunit 1ns;
  timeprecision 1ns;
  // Top orders land past full scale so the sentinel path is hit
  assign harm_cur   = {10'h000, harm_index} * 16'h0026;
  assign harm_ratio = {10'h000, harm_index} * 16'h0082;
  assign scalar     = level;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the measurement query core
`include "mqos_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Signals
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic        [7:0]  paddr = 8'h00;
  logic        [31:0] pwdata = 32'h0;
  logic        [2:0]  out_mode = 3'h1;
  logic               freq_is_50_60 = 1'b1;
  logic               range_high = 1'b0;
  logic        [14:0] event_latch_a_cond_in = 15'h0000;
  logic signed [15:0] level = 16'h0000;
  wire logic   [31:0] prdata;
  wire logic          pready, pslverr, event_latch_a_summary;
  wire logic   [5:0]  meas_harm_index;
  wire logic   [2:0]  disp_sel;
  wire logic signed [15:0] m_cur, m_rat, m_val;
  logic        [31:0] rdv;
  logic               err_last;
  int                 err_total = 0;
  int                 compares = 0;
  int lv[23] = '{-1, 0, 100, 101, 250, 251, -251, 379, 380, 500, 501,
    -501, 1200, 1201, 1400, 1401, 2500, 2501, 5000, 5001, 5250, 5251,
    -5001};
  logic [7:0] regs[6] = '{`MQOS_A_ERRQ, `MQOS_A_COND, `MQOS_A_ENABLE,
    `MQOS_A_EVENT, `MQOS_A_FALL, `MQOS_A_RISE};
  always #50 pclk = ~pclk;
  mqos_core i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .out_mode, .freq_is_50_60,
    .range_high, .event_latch_a_cond_in, .meas_harm_cur(m_cur),
    .meas_harm_ratio(m_rat), .meas_sync_freq(m_val),
    .meas_app_pwr(m_val), .meas_pf(m_val), .meas_reac_pwr(m_val),
    .meas_real_pwr(m_val), .meas_v_rms(m_val), .meas_v_high(m_val),
    .meas_v_low(m_val), .meas_v_avg(m_val), .meas_harm_index,
    .event_latch_a_summary, .disp_sel
  );
  mqos_front_model i_fe (
    .harm_index(meas_harm_index), .level, .harm_cur(m_cur),
    .harm_ratio(m_rat), .scalar(m_val)
  );
  // ======
  // Bus and compare tasks
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      $display("MISMATCH pready expected 1 seen 0");
    end
    rdv      = prdata;
    err_last = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input int op, input int arg);
    apb(1'b1, `MQOS_A_CMD, 32'(arg * 16 + op));
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // Sentinels in the front end's scaled units
  function automatic int xval(int op, int v, bit rh);
    int fs;
    fs = rh ? 500 : 250;
    case (op)
      2: return (v >= 380 && v <= 5250) ? v : 9999;
      3, 5: return (v >= 0 && v <= 1400) ? v : 9999;
      4: return (v >= 0 && v <= 100) ? v : 999;
      6: return (v >= 0 && v <= 1200) ? v : 9999;
      7: return (v >= 0 && v <= fs * 10) ? v : 9999;
      8: return (v >= -fs && v <= fs) ? v : 999;
      9: return (v >= -fs && v <= fs) ? v : -999;
      default: return (v >= -fs * 10 && v <= fs * 10) ? v : 9999;
    endcase
  endfunction
  task automatic harm(input int op, input int g);
    int n;
    int v;
    n = 0;
    cmd(op, g);
    do
    begin
      rd(`MQOS_A_STATUS);
      n++;
    end
    while (rdv[0] !== 1'b0 && n < 40);
    chk("busy", {31'h0, rdv[0]}, 0);
    for (int k = 0; k < 10; k++)
    begin
      v = ((g - 1) * 10 + 1 + k) * (op == 0 ? 38 : 130);
      rd(8'(`MQOS_A_RESP0 + 4 * k));
      chk("harmonic", rdv, v <= (op == 0 ? 1500 : 5000) ? v : 9999);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("MISMATCH watchdog expected done seen hang");
    finish_test();
  end
  // ======
  // Test sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i])
    begin
      rd(regs[i]);
      chk("reset value", rdv, 0);
    end
    apb(1'b1, `MQOS_A_COND, 32'h5002);
    rd(`MQOS_A_COND);
    chk("cond read only", rdv, 0);
    rd(8'h0c);
    chk("unmapped", {31'h0, err_last}, 1);
    done("reset");
    apb(1'b1, `MQOS_A_ENABLE, 32'hffffffff);
    rd(`MQOS_A_ENABLE);
    chk("enable", rdv, 32'h5002);
    apb(1'b1, `MQOS_A_RISE, 32'h0002);
    apb(1'b1, `MQOS_A_FALL, 32'h4000);
    event_latch_a_cond_in <= 15'h7fff;
    repeat (4) @(posedge pclk);
    chk("summary", {31'h0, event_latch_a_summary}, 1);
    rd(`MQOS_A_COND);
    chk("cond", rdv, 32'h5002);
    rd(`MQOS_A_EVENT);
    chk("rise only", rdv, 32'h0002);
    event_latch_a_cond_in <= 15'h0000;
    repeat (4) @(posedge pclk);
    rd(`MQOS_A_EVENT);
    chk("fall only", rdv, 32'h4000);
    apb(1'b1, `MQOS_A_RISE, 32'h1000);
    apb(1'b1, `MQOS_A_FALL, 32'h1000);
    event_latch_a_cond_in <= 15'h1000;
    repeat (4) @(posedge pclk);
    rd(`MQOS_A_EVENT);
    chk("both rise", rdv, 32'h1000);
    event_latch_a_cond_in <= 15'h0000;
    repeat (4) @(posedge pclk);
    apb(1'b1, `MQOS_A_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk("summary off", {31'h0, event_latch_a_summary}, 0);
    rd(`MQOS_A_EVENT);
    chk("both fall", rdv, 32'h1000);
    done("status");
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 23; i++)
        for (int op = 2; op < 11; op++)
        begin
          range_high <= r[0];
          level      <= 16'(lv[i]);
          cmd(op, 0);
          rd(`MQOS_A_RESP0);
          chk("scalar", rdv, xval(op, lv[i], r[0]));
        end
    level <= 16'h01f4;
    for (int m = 0; m < 8; m++)
    begin
      out_mode <= 3'(m);
      cmd(2, 0);
      rd(`MQOS_A_ERRQ);
      chk("mode", rdv, (m == 1 || m == 2) ? 0 : 3);
    end
    done("queries");
    out_mode <= 3'h1;
    for (int d = 0; d < 7; d++)
    begin
      cmd(11, d);
      rd(`MQOS_A_STATUS);
      chk("disp status", {29'h0, rdv[6:4]}, d);
      chk("disp port", {29'h0, disp_sel}, d);
      cmd(12, 0);
      rd(d < 3 ? `MQOS_A_RESP0 : `MQOS_A_ERRQ);
      chk("disp get", rdv, d < 3 ? d : 4);
      if (d > 2)
      begin
        harm(0, d - 2);
        harm(1, d - 2);
      end
    end
    cmd(11, 0);
    out_mode      <= 3'h0;
    freq_is_50_60 <= 1'b0;
    cmd(11, 3);
    rd(`MQOS_A_ERRQ);
    chk("freq refuse", rdv, 6);
    chk("disp kept", {29'h0, disp_sel}, 0);
    freq_is_50_60 <= 1'b1;
    cmd(11, 6);
    @(posedge pclk);
    chk("group ok", {29'h0, disp_sel}, 6);
    cmd(11, 0);
    done("display");
    repeat (21) cmd(2, 0);
    rd(`MQOS_A_STATUS);
    chk("err count", {27'h0, rdv[12:8]}, 20);
    for (int i = 0; i < 21; i++)
    begin
      rd(`MQOS_A_ERRQ);
      chk("errq", rdv, i < 19 ? 3 : (i == 19 ? -350 : 0));
    end
    cmd(2, 0);
    event_latch_a_cond_in <= 15'h1000;
    repeat (4) @(posedge pclk);
    cmd(13, 0);
    rd(`MQOS_A_EVENT);
    chk("cls event", rdv, 0);
    rd(`MQOS_A_ERRQ);
    chk("cls errq", rdv, 0);
    cmd(0, 5);
    rd(`MQOS_A_STATUS);
    chk("group range", {29'h0, rdv[2:0]}, 4);
    done("errors");
    finish_test();
  end
endmodule
`default_nettype wire
